/* File: pkg/cxs_pkg.sv */
// Package for the execution semantics block: opcodes, field types and constants
`default_nettype none
package cxs_pkg;

  // Data path width and auto-increment step
  localparam int unsigned WORD_W        = 16;
  localparam logic [15:0] AUTOINC_STEP  = 16'h0001;
  localparam logic [15:0] STACK_STEP    = 16'h0002;
  localparam logic [15:0] MOST_NEG_WORD = 16'h8000;

  // Reset values
  localparam logic [15:0] SP_RESET      = 16'h0000;
  localparam logic [15:0] WORD_RESET    = 16'h0000;

  // Opcode encodings served by this block
  localparam logic [7:0]  OPC_NEG       = 8'h03;
  localparam logic [7:0]  OPC_ST_AI     = 8'hC3;
  localparam logic [7:0]  OPC_PUSH      = 8'hC8;
  localparam logic [7:0]  OPC_POP       = 8'hCC;
  localparam logic [7:0]  OPC_TRAP      = 8'hEE;

  // Decoded operation kinds
  typedef enum logic [2:0] {
    CXS_K_NEG,
    CXS_K_ST_AI,
    CXS_K_PUSH,
    CXS_K_POP,
    CXS_K_TRAP
  } cxs_kind_t;

  // Instruction request from the sequencer
  typedef struct packed {
    logic [7:0]  opcode;
    logic [15:0] ind_reg;   // Value of the indirect/operand register
    logic [15:0] src_data;  // Store or push data, or negate operand
  } cxs_req_t;

  // Memory request toward the data bus
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cxs_mem_t;

  // Completion record
  typedef struct packed {
    logic [15:0] value;     // Negate result or popped word
    logic [15:0] ptr_wb;    // Updated indirect register after auto-increment
    logic        ptr_wb_en;
    logic        flag_n;
    logic        flag_v;
    logic        flag_z;
  } cxs_res_t;

endpackage

`default_nettype wire

/* File: core/cxs_exec.sv */
// Execution unit covering auto-increment, negate flags, reserved-opcode trap and stack pointer
//
// Contract
// - Indirect auto-increment addresses with original value; increment applied at instruction end.
// - Negating 8000h returns 8000h with negative and overflow flags both set.
// - Opcode EEH always raises the unimplemented-opcode interrupt.
// - Stack pointer is a dedicated register, also usable as general storage.
`timescale 1ns/10ps
`default_nettype none

module cxs_exec #(
  // Word width of the data path; only the core word width is served
  parameter int unsigned DATA_W = cxs_pkg::WORD_W
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // Instruction request
  input  wire logic              req_valid,
  input  wire cxs_pkg::cxs_req_t req,
  output logic                   req_ready,
  // Data memory
  output cxs_pkg::cxs_mem_t      mem,
  input  wire logic [15:0]       mem_rdata,
  // Completion
  output logic                   done,
  output cxs_pkg::cxs_res_t      res,
  output logic                   unimpl_irq,
  // Stack pointer as general storage
  input  wire logic              sp_wr,
  input  wire logic [15:0]       sp_wdata,
  output logic [15:0]            stack_pointer_register
);

  typedef enum logic [1:0] {
    CXS_S_IDLE,
    CXS_S_MEM,
    CXS_S_END
  } cxs_state_t;

  cxs_state_t          state_ff;
  cxs_state_t          nxt_state;
  cxs_pkg::cxs_kind_t  kind_ff;
  logic [DATA_W-1:0]   ptr_ff;
  logic [DATA_W-1:0]   sp_ff;
  logic                ready_ff;
  logic                done_ff;
  logic                irq_ff;
  cxs_pkg::cxs_mem_t   mem_ff;
  cxs_pkg::cxs_res_t   res_ff;
  logic                take;
  cxs_pkg::cxs_kind_t  kind_in;

  // Refuse widths that the packed carriers cannot hold
  if (DATA_W != cxs_pkg::WORD_W) begin : g_width_check
    $error("cxs_exec: DATA_W must equal the core word width");
  end

  // Operations that walk the memory states before completing
  function automatic logic is_mem_op(input cxs_pkg::cxs_kind_t k);
    is_mem_op = (k == cxs_pkg::CXS_K_ST_AI) || (k == cxs_pkg::CXS_K_PUSH) ||
                (k == cxs_pkg::CXS_K_POP);
  endfunction

  // Stack grows downward by one word per push
  function automatic logic [15:0] sp_down(input logic [15:0] sp);
    sp_down = sp - cxs_pkg::STACK_STEP;
  endfunction

  // Stack shrinks upward by one word per pop
  function automatic logic [15:0] sp_up(input logic [15:0] sp);
    sp_up = sp + cxs_pkg::STACK_STEP;
  endfunction

  // Maps an opcode to its operation; anything unknown traps
  // Reserved code EEH and every unlisted code land on the same trap
  function automatic cxs_pkg::cxs_kind_t decode(input logic [7:0] opc);
    case (opc)
      cxs_pkg::OPC_NEG:   decode = cxs_pkg::CXS_K_NEG;
      cxs_pkg::OPC_ST_AI: decode = cxs_pkg::CXS_K_ST_AI;
      cxs_pkg::OPC_PUSH:  decode = cxs_pkg::CXS_K_PUSH;
      cxs_pkg::OPC_POP:   decode = cxs_pkg::CXS_K_POP;
      cxs_pkg::OPC_TRAP:  decode = cxs_pkg::CXS_K_TRAP;
      default:            decode = cxs_pkg::CXS_K_TRAP;
    endcase
  endfunction

  assign take    = req_valid && ready_ff;
  assign kind_in = decode(req.opcode);

  // Next state: single-cycle ops stay idle, memory ops walk MEM then END
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CXS_S_IDLE: begin
        if (take && is_mem_op(kind_in)) begin
          nxt_state = CXS_S_MEM;
        end
      end
      CXS_S_MEM: nxt_state = CXS_S_END;
      CXS_S_END: nxt_state = CXS_S_IDLE;
      default:   nxt_state = CXS_S_IDLE;
    endcase
  end

  // State, ready and captured operation
  // Ready drops for the two cycles a memory operation is in flight
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_ff <= CXS_S_IDLE;
      ready_ff <= 1'b0;
      kind_ff  <= cxs_pkg::CXS_K_NEG;
      ptr_ff   <= cxs_pkg::WORD_RESET;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= (nxt_state == CXS_S_IDLE);
      if (take) begin
        kind_ff <= kind_in;
        ptr_ff  <= req.ind_reg; // Original pointer kept until the end
      end
    end
  end

  // Memory strobes, one cycle each
  // Address and data hold after the strobe so the bus sees stable values
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mem_ff <= '0;
    end else begin
      mem_ff.wr <= 1'b0;
      mem_ff.rd <= 1'b0;
      if (take) begin
        case (kind_in)
          cxs_pkg::CXS_K_ST_AI: begin
            mem_ff.wr    <= 1'b1;
            mem_ff.addr  <= req.ind_reg;  // Pre-increment address
            mem_ff.wdata <= req.src_data; // Same register stores its old value
          end
          cxs_pkg::CXS_K_PUSH: begin
            mem_ff.wr    <= 1'b1;
            mem_ff.addr  <= sp_down(sp_ff);
            mem_ff.wdata <= req.src_data;
          end
          cxs_pkg::CXS_K_POP: begin
            mem_ff.rd    <= 1'b1;
            mem_ff.addr  <= sp_ff;
          end
          default: begin
            mem_ff.addr  <= mem_ff.addr;
          end
        endcase
      end
    end
  end

  // Stack pointer: instruction updates win over a general-storage write
  // A storage write on the edge that ends a push or pop is dropped, so
  // software must not use the register as storage while the stack is live
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sp_ff <= cxs_pkg::SP_RESET;
    end else if (state_ff == CXS_S_END && kind_ff == cxs_pkg::CXS_K_PUSH) begin
      sp_ff <= sp_down(sp_ff);
    end else if (state_ff == CXS_S_END && kind_ff == cxs_pkg::CXS_K_POP) begin
      sp_ff <= sp_up(sp_ff);
    end else if (sp_wr) begin
      sp_ff <= sp_wdata; // Plain storage when no stack is in use
    end
  end

  // Completion pulse, result record and trap
  // Negating the most negative word keeps 8000h and reports it as negative
  // as well as overflowed, so a sign test after the negate stays consistent
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      done_ff <= 1'b0;
      irq_ff  <= 1'b0;
      res_ff  <= '0;
    end else begin
      done_ff          <= 1'b0;
      irq_ff           <= 1'b0;
      res_ff.ptr_wb_en <= 1'b0;
      if (take && kind_in == cxs_pkg::CXS_K_NEG) begin
        done_ff      <= 1'b1;
        res_ff.value <= 16'h0000 - req.src_data;
        res_ff.flag_n <= req.src_data != 16'h0000 && !(req.src_data[15] &&
                         req.src_data != cxs_pkg::MOST_NEG_WORD); // N set for 8000h
        res_ff.flag_v <= (req.src_data == cxs_pkg::MOST_NEG_WORD);
        res_ff.flag_z <= (req.src_data == 16'h0000);
      end else if (take && kind_in == cxs_pkg::CXS_K_TRAP) begin
        done_ff <= 1'b1;
        irq_ff  <= 1'b1;
      end else if (state_ff == CXS_S_END) begin
        done_ff <= 1'b1;
        if (kind_ff == cxs_pkg::CXS_K_ST_AI) begin
          res_ff.ptr_wb    <= ptr_ff + cxs_pkg::AUTOINC_STEP; // Increment at end
          res_ff.ptr_wb_en <= 1'b1;
        end
        if (kind_ff == cxs_pkg::CXS_K_POP) begin
          res_ff.value  <= mem_rdata;
          res_ff.flag_z <= (mem_rdata == 16'h0000);
          res_ff.flag_n <= mem_rdata[15];
          res_ff.flag_v <= 1'b0;
        end
      end
    end
  end

  // Pending interrupt flags live outside this unit; the trap only pulses
  // its request line, and updates to the pending flags stay with software
  // that must keep them safe from lost requests
  // Outputs straight from flip-flops
  assign req_ready              = ready_ff;
  assign mem                    = mem_ff;
  assign done                   = done_ff;
  assign res                    = res_ff;
  assign unimpl_irq             = irq_ff;
  assign stack_pointer_register = sp_ff;

endmodule

`default_nettype wire

/* File: tb/cxs_exec_assertions.sv */
// Port checker for the execution unit
`timescale 1ns/10ps
`default_nettype none
module cxs_exec_chk (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rstn,
  // Request and memory
  input wire logic              req_valid,
  input wire cxs_pkg::cxs_req_t req,
  input wire logic              req_ready,
  input wire cxs_pkg::cxs_mem_t mem,
  input wire logic [15:0]       mem_rdata,
  // Completion and stack
  input wire logic              done,
  input wire cxs_pkg::cxs_res_t res,
  input wire logic              unimpl_irq,
  input wire logic              sp_wr,
  input wire logic [15:0]       sp_wdata,
  input wire logic [15:0]       stack_pointer_register
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Request taken at this edge
  logic        tk;
  assign tk = req_valid && req_ready;
  auto_inc_a: assert property (tk && req.opcode == cxs_pkg::OPC_ST_AI |=>
    mem.wr && mem.addr == $past(req.ind_reg) && mem.wdata == $past(req.src_data) ##2
    done && res.ptr_wb == $past(req.ind_reg, 3) + 16'h0001) else $error("auto-increment wrong");
  neg_flags_a: assert property (tk && req.opcode == cxs_pkg::OPC_NEG &&
    req.src_data == 16'h8000 |=> done && res.value == 16'h8000 && res.flag_n && res.flag_v)
    else $error("negate of most negative word wrong");
  trap_irq_a: assert property (tk && req.opcode == cxs_pkg::OPC_TRAP |=> done && unimpl_irq)
    else $error("reserved opcode did not trap");
  push_sp_a: assert property (tk && req.opcode == cxs_pkg::OPC_PUSH |=>
    mem.wr && mem.addr == $past(stack_pointer_register) - 16'h0002 ##2
    stack_pointer_register == $past(stack_pointer_register, 3) - 16'h0002)
    else $error("push pointer wrong");
  sp_store_a: assert property (sp_wr && req_ready && !req_valid |=>
    stack_pointer_register == $past(sp_wdata)) else $error("stack pointer store lost");
  pop_sp_a: assert property (tk && req.opcode == cxs_pkg::OPC_POP |=>
    mem.rd && mem.addr == $past(stack_pointer_register) ##2
    done && res.value == $past(mem_rdata) &&
    stack_pointer_register == $past(stack_pointer_register, 3) + 16'h0002)
    else $error("pop pointer or data wrong");
  // Main scenarios reached
  cover property (done && unimpl_irq);
  cover property (done && res.flag_n && res.flag_v);
  cover property (mem.rd);
  cover property (done && res.ptr_wb_en);
endmodule
bind cxs_exec cxs_exec_chk chk (
  .core_clk               (core_clk),
  .rstn                   (rstn),
  .req_valid              (req_valid),
  .req                    (req),
  .req_ready              (req_ready),
  .mem                    (mem),
  .mem_rdata              (mem_rdata),
  .done                   (done),
  .res                    (res),
  .unimpl_irq             (unimpl_irq),
  .sp_wr                  (sp_wr),
  .sp_wdata               (sp_wdata),
  .stack_pointer_register (stack_pointer_register)
);
`default_nettype wire

/* File: tb/cxs_exec_test.sv */
// Self-checking bench for the execution unit
`timescale 1ns/10ps
`default_nettype none
module cxs_exec_test;
  logic              core_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, sp_wr = 1'b0;
  cxs_pkg::cxs_req_t req = '0;
  logic [15:0]       mem_rdata = 16'h0000, sp_wdata = 16'h0000, stack_pointer_register;
  logic              req_ready, done, unimpl_irq;
  cxs_pkg::cxs_mem_t mem;
  cxs_pkg::cxs_res_t res;
  int                bad_count = 0, cmp_count = 0, cyc = 0;
  always #4 core_clk = ~core_clk;
  cxs_exec uut (
    .core_clk               (core_clk),
    .rstn                   (rstn),
    .req_valid              (req_valid),
    .req                    (req),
    .req_ready              (req_ready),
    .mem                    (mem),
    .mem_rdata              (mem_rdata),
    .done                   (done),
    .res                    (res),
    .unimpl_irq             (unimpl_irq),
    .sp_wr                  (sp_wr),
    .sp_wdata               (sp_wdata),
    .stack_pointer_register (stack_pointer_register)
  );
  // Compare and report
  task automatic chk(input string nm, input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic step;
    @(posedge core_clk);
    #1;
  endtask
  // Present a request until taken; valid is left high for back-to-back use
  task automatic send(input logic [7:0] op, input logic [15:0] ind, src);
    while (req_ready !== 1'b1) step();
    req_valid = 1'b1;
    req = {op, ind, src};
    step();
  endtask
  task automatic t_store;
    send(cxs_pkg::OPC_ST_AI, 16'h1000, 16'h1000);
    req_valid = 1'b0;
    chk("st addr", mem.wr ? mem.addr : 16'h0000, 16'h1000);
    chk("st data", mem.wdata, 16'h1000);
    step();
    step();
    chk("st ptr", {res.ptr_wb_en & done, res.ptr_wb[14:0]}, 16'h9001);
  endtask
  task automatic t_neg_trap;
    send(cxs_pkg::OPC_TRAP, 16'h0000, 16'h0000);
    chk("trap", {15'h0, unimpl_irq & done}, 16'h0001);
    send(8'hA7, 16'h0000, 16'h0000);
    chk("unk trap", {15'h0, unimpl_irq & done}, 16'h0001);
    send(cxs_pkg::OPC_NEG, 16'h0000, 16'h8000);
    chk("neg val", res.value, 16'h8000);
    chk("neg nv", {12'h0, done, unimpl_irq, res.flag_n, res.flag_v}, 16'h000B);
    chk("neg z8", {15'h0, res.flag_z}, 16'h0000);
    send(cxs_pkg::OPC_NEG, 16'h0000, 16'h0001);
    chk("neg one", {res.value[15:2], res.flag_n, res.flag_v}, 16'hFFFE);
    send(cxs_pkg::OPC_NEG, 16'h0000, 16'h0000);
    req_valid = 1'b0;
    chk("neg zero", res.value, 16'h0000);
    chk("neg zf", {13'h0, res.flag_n, res.flag_v, res.flag_z}, 16'h0001);
  endtask
  task automatic t_stack;
    sp_wr = 1'b1;
    sp_wdata = 16'h0100;
    step();
    sp_wr = 1'b0;
    chk("sp store", stack_pointer_register, 16'h0100);
    send(cxs_pkg::OPC_PUSH, 16'h0000, 16'hA5C3);
    req_valid = 1'b0;
    chk("push addr", mem.wr ? mem.addr : 16'h0000, 16'h00FE);
    step();
    step();
    chk("push sp", stack_pointer_register, 16'h00FE);
    send(cxs_pkg::OPC_POP, 16'h0000, 16'h0000);
    req_valid = 1'b0;
    chk("pop addr", mem.rd ? mem.addr : 16'h0000, 16'h00FE);
    step();
    mem_rdata = 16'h5A3C;
    step();
    mem_rdata = 16'hA5C3;
    chk("pop val", res.value, 16'h5A3C);
    chk("pop sp", stack_pointer_register, 16'h0100);
    chk("pop flags", {13'h0, res.flag_n, res.flag_v, res.flag_z}, 16'h0000);
  endtask
  // Main sequence
  initial begin
    repeat (3) step();
    chk("rst sp", stack_pointer_register, 16'h0000);
    rstn = 1'b1;
    t_store();
    t_neg_trap(); // Trap only pulses; no pending-flag rewrite is issued
    t_stack();
    repeat (2) step(); // Let the trailing checker windows close
    complete_run();
  end
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 500) begin
      bad_count++;
      complete_run();
    end
  end
endmodule
`default_nettype wire
